// file: scq_pkg.sv
// Constants and types shared by the serial controller with its documented deviations.
// Assumes a 20 MHz core clock and an optional external master clocking the slave side.
//
// Contract
// - One soft reset may leave serial clock running before chip select asserts.
// - Hold select with divider one: second back-to-back word stays ready-low, resent.
// - Fixed, held, DMA-fed: final flag bit 24 drops select once drained.
// - Master mode may toggle serial clock before the first transfer.
// - Fixed-mode DMA size always follows chip select 0 word length.
// - Divider one with odd word length emits one extra serial clock pulse.
// - Divider one with even word length gives the correct pulse count.
// - Disable command is ignored in slave mode.
package scq_pkg;

    localparam int          DATA_W        = 16;
    localparam int          WORD_W        = 32;
    localparam int          LEN_CODE_W    = 4;
    localparam int          LEN_W         = 5;
    localparam int          DIV_W         = 8;
    localparam int          NUM_SEL       = 4;
    localparam int          SEL_W         = 2;
    localparam int          FINAL_BIT     = 24;
    localparam int          SEL_FIELD_LSB = 16;
    localparam logic [LEN_W-1:0]      LEN_BASE    = 5'h08;
    localparam logic [LEN_CODE_W-1:0] LEN_RESET   = 4'h0;
    localparam logic [DIV_W-1:0]      DIV_ONE     = 8'h01;
    localparam logic [DATA_W-1:0]     DATA_RESET  = 16'h0000;
    localparam logic [NUM_SEL-1:0]    SEL_IDLE    = 4'hF;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_SHIFT = 2'b10,
        ST_TAIL  = 2'b11
    } scq_state_t;

    typedef struct packed {
        logic              dmaFeed;
        logic [WORD_W-1:0] word;
    } scq_tx_t;

    typedef struct packed {
        logic                  cfgWrite;
        logic [SEL_W-1:0]      cfgIndex;
        logic [LEN_CODE_W-1:0] cfgWordLen;
    } scq_cfg_t;

endpackage : scq_pkg

// file: scq_controller.sv
// Serial peripheral controller: master engine on core_clk, slave receiver on the link clock.
// Assumes control strobes are one-cycle pulses from core_clk logic; pins are asynchronous.
module scq_controller
    import scq_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic                 slaveClk,
    input  wire logic                 softResetCmd,
    input  wire logic                 enableCmd,
    input  wire logic                 disableCmd,
    input  wire logic                 masterSel,
    input  wire logic                 fixedMode,
    input  wire logic                 holdSelect,
    input  wire logic [SEL_W-1:0]     selIndex,
    input  wire logic [DIV_W-1:0]     clockDivider,
    input  wire scq_cfg_t             cfgIn,
    input  wire logic                 txValid,
    input  wire scq_tx_t              txIn,
    output logic                      txReady,
    input  wire logic                 rxTake,
    output logic                      rxValid,
    output logic [DATA_W-1:0]         rxData,
    output logic                      enabled,
    output logic                      transmitDrained,
    output logic                      dmaHalfword,
    output logic                      sclkOut,
    output logic                      sclkOutEn,
    output logic                      dataOut,
    output logic                      dataOutEn,
    input  wire logic                 dataIn,
    input  wire logic                 selIn_n,
    output logic [NUM_SEL-1:0]        selOut_n
);

    function automatic logic [LEN_W-1:0] wordBits(input logic [LEN_CODE_W-1:0] code);
        wordBits = LEN_BASE + {1'b0, code};
    endfunction : wordBits

    ////////////////////////////////////////////////////////////////////////////////////
    logic                       localReset;
    logic                       faulty_q;
    logic                       enabled_q;
    logic                       glitchArm_q;
    logic                       glitch_q;
    logic [LEN_CODE_W-1:0]      cfgLen_q [NUM_SEL];
    logic                       holdFull_q;
    scq_tx_t                    hold_q;
    logic                       resend_q;
    scq_state_t                 state_q;
    logic [DIV_W-1:0]           halfCnt_q;
    logic                       phase_q;
    logic [LEN_W-1:0]           bitCnt_q;
    logic [DATA_W-1:0]          txShift_q;
    logic [DATA_W-1:0]          rxShift_q;
    logic                       final_q;
    logic                       oddExtra_q;
    logic [SEL_W-1:0]           curSel_q;
    logic                       selHeld_q;
    logic [SEL_W-1:0]           heldSel_q;
    logic                       rxValid_q;
    logic [DATA_W-1:0]          rxData_q;
    logic                       dinMeta_q;
    logic                       dinSync_q;
    logic [SEL_W-1:0]           wordSel;
    logic [LEN_W-1:0]           wordLen;
    logic                       halfDone;
    logic                       load;
    logic                       finish;
    logic                       slaveDone;

    assign localReset = !rst_n || softResetCmd;
    assign wordSel    = fixedMode ? selIndex
                                  : hold_q.word[SEL_FIELD_LSB +: SEL_W];
    assign wordLen    = wordBits(cfgLen_q[wordSel]);
    assign halfDone   = (halfCnt_q == DIV_ONE) || (clockDivider <= DIV_ONE);
    assign load       = (state_q == ST_IDLE) && enabled_q && masterSel && holdFull_q
                        && !glitch_q;
    assign finish     = ((state_q == ST_SHIFT) && halfDone && phase_q
                         && (bitCnt_q == wordLen - 5'h01) && !oddExtra_q)
                        || ((state_q == ST_TAIL) && halfDone && phase_q);
    assign txReady    = !holdFull_q;

    ////////////////////////////////////////////////////////////////////////////////////
    // A first soft reset arms the fault and a second one in succession clears it.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            faulty_q <= 1'b0;
        end else if (softResetCmd) begin
            faulty_q <= !faulty_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (localReset) begin
            enabled_q <= 1'b0;
        end else if (enableCmd) begin
            enabled_q <= 1'b1;
        end else if (disableCmd && masterSel) begin
            enabled_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (localReset) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                cfgLen_q[i] <= LEN_RESET;
            end
        end else if (cfgIn.cfgWrite) begin
            cfgLen_q[cfgIn.cfgIndex] <= cfgIn.cfgWordLen;
        end
    end

    // Configuring selects before master select leaves a stray clock edge pending.
    always_ff @(posedge core_clk) begin
        if (localReset) begin
            glitchArm_q <= 1'b0;
            glitch_q    <= 1'b0;
        end else begin
            glitch_q <= glitchArm_q && masterSel && enabled_q && (state_q == ST_IDLE);
            if (cfgIn.cfgWrite && !masterSel) begin
                glitchArm_q <= 1'b1;
            end else if (glitch_q) begin
                glitchArm_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // The holding register is freed on load, except when a held select at divider one
    // swallows the ready edge; the word is then shifted a second time.
    always_ff @(posedge core_clk) begin
        if (localReset) begin
            holdFull_q <= 1'b0;
            hold_q     <= '0;
            resend_q   <= 1'b0;
        end else if (txValid && txReady) begin
            holdFull_q <= 1'b1;
            hold_q     <= txIn;
        end else if (load) begin
            if (holdSelect && (clockDivider == DIV_ONE) && selHeld_q
                && (heldSel_q == wordSel) && !resend_q) begin
                resend_q <= 1'b1;
            end else begin
                holdFull_q <= 1'b0;
                resend_q   <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (localReset) begin
            state_q    <= ST_IDLE;
            halfCnt_q  <= DIV_ONE;
            phase_q    <= 1'b0;
            bitCnt_q   <= '0;
            txShift_q  <= DATA_RESET;
            rxShift_q  <= DATA_RESET;
            final_q    <= 1'b0;
            oddExtra_q <= 1'b0;
            curSel_q   <= '0;
        end else begin
            halfCnt_q <= (halfDone || state_q == ST_IDLE) ? clockDivider : halfCnt_q - DIV_ONE;
            case (state_q)
                ST_IDLE: begin
                    phase_q  <= 1'b0;
                    bitCnt_q <= '0;
                    if (load) begin
                        txShift_q  <= hold_q.word[DATA_W-1:0] << (LEN_W'(DATA_W) - wordLen);
                        // Cleared so a short word is handed over right aligned with zeros above.
                        rxShift_q  <= DATA_RESET;
                        final_q    <= hold_q.word[FINAL_BIT];
                        curSel_q   <= wordSel;
                        oddExtra_q <= (clockDivider == DIV_ONE) && wordLen[0];
                        state_q    <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    if (halfDone) begin
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (halfDone) begin
                        phase_q <= !phase_q;
                        if (!phase_q) begin
                            rxShift_q <= {rxShift_q[DATA_W-2:0], dinSync_q};
                        end else begin
                            txShift_q <= {txShift_q[DATA_W-2:0], 1'b0};
                            bitCnt_q  <= bitCnt_q + 5'h01;
                            if (bitCnt_q == wordLen - 5'h01) begin
                                state_q <= oddExtra_q ? ST_TAIL : ST_IDLE;
                            end
                        end
                    end
                end
                ST_TAIL: begin
                    if (halfDone) begin
                        phase_q <= !phase_q;
                        if (phase_q) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Select stays low after a word only when held; a final-flagged DMA word written
    // in fixed mode while drained releases it at once, before that word is even shifted.
    always_ff @(posedge core_clk) begin
        if (localReset) begin
            selHeld_q <= 1'b0;
            heldSel_q <= '0;
        end else if (finish) begin
            selHeld_q <= holdSelect && !final_q;
            heldSel_q <= curSel_q;
        end else if (fixedMode && holdSelect && transmitDrained && txValid && txIn.dmaFeed
                     && txIn.word[FINAL_BIT]) begin
            selHeld_q <= 1'b0;
        end else if (!holdSelect) begin
            selHeld_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dinMeta_q <= 1'b0;
            dinSync_q <= 1'b0;
        end else begin
            dinMeta_q <= dataIn;
            dinSync_q <= dinMeta_q;
        end
    end

    // Link side: shifts on the external master's clock; the frame's own select ends it.
    logic                  linkRst_q;
    logic [LEN_W-1:0]      slvCnt_q;
    logic [DATA_W-1:0]     slvShift_q;
    logic [DATA_W-1:0]     slvWord_q;
    logic                  slvTgl_q;
    logic [LEN_CODE_W-1:0] lenMeta_q;
    logic [LEN_CODE_W-1:0] lenSync_q;
    logic [2:0]            tglSync_q;

    always_ff @(posedge core_clk) begin
        linkRst_q <= localReset || masterSel;
    end

    always_ff @(posedge slaveClk or posedge selIn_n) begin
        if (selIn_n) begin
            slvCnt_q <= '0;
        end else begin
            slvCnt_q <= (slvCnt_q == wordBits(lenSync_q) - 5'h01) ? '0 : slvCnt_q + 5'h01;
        end
    end

    // Length is quasi-static; software must not change it during a slave frame.
    always_ff @(posedge slaveClk or posedge linkRst_q) begin
        if (linkRst_q) begin
            lenMeta_q  <= LEN_RESET;
            lenSync_q  <= LEN_RESET;
            slvShift_q <= DATA_RESET;
            slvWord_q  <= DATA_RESET;
            slvTgl_q   <= 1'b0;
        end else begin
            lenMeta_q <= cfgLen_q[0];
            lenSync_q <= lenMeta_q;
            if (!selIn_n) begin
                slvShift_q <= {slvShift_q[DATA_W-2:0], dataIn};
                if (slvCnt_q == wordBits(lenSync_q) - 5'h01) begin
                    slvWord_q <= {slvShift_q[DATA_W-2:0], dataIn};
                    slvTgl_q  <= !slvTgl_q;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (localReset) begin
            tglSync_q <= '0;
        end else begin
            tglSync_q <= {tglSync_q[1:0], slvTgl_q};
        end
    end

    assign slaveDone = (tglSync_q[2] != tglSync_q[1]) && !masterSel && enabled_q;

    // A new word wins over a take in the same cycle.
    always_ff @(posedge core_clk) begin
        if (localReset) begin
            rxValid_q <= 1'b0;
            rxData_q  <= DATA_RESET;
        end else if (finish) begin
            rxValid_q <= 1'b1;
            rxData_q  <= rxShift_q;
        end else if (slaveDone) begin
            rxValid_q <= 1'b1;
            rxData_q  <= slvWord_q;
        end else if (rxTake) begin
            rxValid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (localReset) begin
            sclkOut         <= 1'b0;
            selOut_n        <= SEL_IDLE;
            transmitDrained <= 1'b1;
            dmaHalfword     <= 1'b0;
            dataOut         <= 1'b0;
        end else begin
            sclkOut <= glitch_q
                       || ((state_q == ST_LEAD) && faulty_q)
                       || (((state_q == ST_SHIFT) || (state_q == ST_TAIL)) && phase_q);
            selOut_n <= SEL_IDLE;
            if ((state_q != ST_IDLE) && !((state_q == ST_LEAD) && faulty_q)) begin
                selOut_n[curSel_q] <= 1'b0;
            end else if (selHeld_q) begin
                selOut_n[heldSel_q] <= 1'b0;
            end
            transmitDrained <= (state_q == ST_IDLE) && !holdFull_q && !load;
            dmaHalfword <= fixedMode ? (cfgLen_q[0] != LEN_RESET)
                                     : (cfgLen_q[wordSel] != LEN_RESET);
            dataOut <= txShift_q[DATA_W-1];
        end
    end

    assign sclkOutEn = masterSel && enabled_q;
    assign dataOutEn = masterSel && enabled_q;
    assign rxValid   = rxValid_q;
    assign rxData    = rxData_q;
    assign enabled   = enabled_q;

endmodule : scq_controller

// file: scq_controller_props.sv
// Port checker for the serial controller and its documented quirks.
// Assumes a bind onto scq_controller; all checks run in the core clock domain.
module scq_controller_props
    import scq_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               rst_n,
    input wire logic               slaveClk,
    input wire logic               softResetCmd,
    input wire logic               disableCmd,
    input wire logic               masterSel,
    input wire logic               fixedMode,
    input wire logic               holdSelect,
    input wire scq_cfg_t           cfgIn,
    input wire logic               txValid,
    input wire scq_tx_t            txIn,
    input wire logic               txReady,
    input wire logic               rxTake,
    input wire logic               rxValid,
    input wire logic               enabled,
    input wire logic               transmitDrained,
    input wire logic               dmaHalfword,
    input wire logic               sclkOut,
    input wire logic [NUM_SEL-1:0] selOut_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic                  faultQ;
    logic                  strayQ;
    logic [LEN_CODE_W-1:0] len0Q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
////////////////////////////////////////////////////////////
    // Parity of soft resets, a slave-mode configuration write, and the select 0 length.
    always_ff @(posedge core_clk) begin
        if (!rst_n || softResetCmd) begin
            faultQ <= rst_n && !faultQ;
            strayQ <= 1'h0;
            len0Q  <= LEN_RESET;
        end else if (cfgIn.cfgWrite) begin
            strayQ <= strayQ || !masterSel;
            len0Q  <= (cfgIn.cfgIndex == '0) ? cfgIn.cfgWordLen : len0Q;
        end
    end
////////////////////////////////////////////////////////////
    sequence s_accept;
        txValid && txReady && masterSel && enabled && transmitDrained && !faultQ && !softResetCmd;
    endsequence
    sequence s_quiet;
        (!softResetCmd && !disableCmd) [*2];
    endsequence
    property p_selectTimely;
        s_accept ##1 s_quiet |=> selOut_n != SEL_IDLE;
    endproperty
    a_selectTimely: assert property (p_selectTimely) else $error("select late");
    property p_softReset;
        softResetCmd |=> selOut_n == SEL_IDLE && !enabled && transmitDrained && !rxValid
            && !sclkOut && txReady;
    endproperty
    a_softReset: assert property (p_softReset) else $error("soft reset incomplete");
    property p_slaveKeepsOn;
        !masterSel && enabled && disableCmd && !softResetCmd |=> enabled;
    endproperty
    a_slaveKeepsOn: assert property (p_slaveKeepsOn) else $error("slave disabled");
    property p_holdTaken;
        txValid && txReady && !softResetCmd |=> !txReady;
    endproperty
    a_holdTaken: assert property (p_holdTaken) else $error("holding not taken");
    property p_rxStands;
        rxValid && !rxTake && !softResetCmd |=> rxValid;
    endproperty
    a_rxStands: assert property (p_rxStands) else $error("receive flag lost");
    property p_cleanLead;
        !faultQ && !strayQ && sclkOut |-> selOut_n != SEL_IDLE;
    endproperty
    a_cleanLead: assert property (p_cleanLead) else $error("clock without select");
    property p_faultLead;
        faultQ && $fell(&selOut_n) |-> $past(sclkOut);
    endproperty
    a_faultLead: assert property (p_faultLead) else $error("fault lead missing");
    property p_finalRelease;
        fixedMode && holdSelect && transmitDrained && txValid && txReady && txIn.dmaFeed
            && txIn.word[FINAL_BIT] && !softResetCmd |-> ##[1:2] selOut_n == SEL_IDLE;
    endproperty
    a_finalRelease: assert property (p_finalRelease) else $error("held select kept");
    property p_sizeSel0;
        fixedMode && !transmitDrained && selOut_n != SEL_IDLE
            |-> dmaHalfword == (len0Q != LEN_RESET);
    endproperty
    a_sizeSel0: assert property (p_sizeSel0) else $error("size not from select 0");
endmodule : scq_controller_props

bind scq_controller scq_controller_props u_props (.*);

// file: scq_slave_model.sv
// Behavioural serial slave on select 0 of the controller's master engine.
// Assumes clock, select and data arrive straight from the controller's pins.
module scq_slave_model
    import scq_pkg::*;
(
    input  wire logic              sclk,
    input  wire logic              select_n,
    input  wire logic              mosi,
    input  wire logic [DATA_W-1:0] reply,
    input  wire logic [LEN_W-1:0]  bitLen,
    output logic                   miso,
    output logic [DATA_W-1:0]      captured,
    output int                     pulses
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] shiftQ;
    initial begin
        miso     = 1'h0;
        captured = '0;
        pulses   = 0;
        shiftQ   = '0;
    end
    // The reply is right aligned, so it is moved up to put its top bit out first.
    always @(negedge select_n) begin
        pulses   = 0;
        captured = '0;
        shiftQ   = reply << (DATA_W - int'(bitLen));
        miso     = shiftQ[DATA_W-1];
    end
    always @(posedge sclk) begin
        if (!select_n) begin
            pulses++;
            if (pulses <= int'(bitLen)) captured = {captured[DATA_W-2:0], mosi};
        end
    end
    always @(negedge sclk) begin
        if (!select_n) begin
            shiftQ = shiftQ << 1;
            miso   = shiftQ[DATA_W-1];
        end
    end
    // A released line must not look as if it kept its level.
    always @(posedge select_n) miso = !miso;
endmodule : scq_slave_model

// file: test_scq_controller.sv
// Self-checking bench for the serial controller quirks.
// Assumes the package, controller, bound checker and slave model are compiled first.
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin failCount++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module test_scq_controller
    import scq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic               core_clk = 1'h0, rst_n = 1'h0, slaveClk = 1'h0, slvRun = 1'h0;
    logic               softResetCmd = 1'h0, enableCmd = 1'h0, disableCmd = 1'h0;
    logic               masterSel = 1'h0, fixedMode = 1'h0, holdSelect = 1'h0;
    logic               txValid = 1'h0, rxTake = 1'h0, selIn_n = 1'h1, slvData = 1'h0;
    logic [SEL_W-1:0]   selIndex = '0;
    logic [DIV_W-1:0]   clockDivider = 8'h02;
    scq_cfg_t           cfgIn = '0;
    scq_tx_t            txIn = '0;
    logic [DATA_W-1:0]  reply = '0, rxData, captured;
    logic [LEN_W-1:0]   curLen = LEN_BASE;
    logic               txReady, rxValid, enabled, transmitDrained, dmaHalfword;
    logic               sclkOut, sclkOutEn, dataOut, dataOutEn, modelMiso;
    logic [NUM_SEL-1:0] selOut_n;
    int                 pulses, failCount = 0, checkCount = 0, strayCount = 0;
    wire logic          dataIn = masterSel ? modelMiso : slvData;
    always #25 core_clk = !core_clk;
    always #62.5 slaveClk = slvRun && !slaveClk;
    always @(posedge sclkOut) if (selOut_n === SEL_IDLE) strayCount++;
    scq_controller DUT (.*);
    scq_slave_model u_slave (.sclk(sclkOut), .select_n(selOut_n[0]), .mosi(dataOut),
        .reply(reply), .bitLen(curLen), .miso(modelMiso), .captured(captured), .pulses(pulses));
////////////////////////////////////////////////////////////
    task automatic endSim;
        if (failCount == 0 && checkCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : endSim
    task automatic strobe(ref logic s);
        @(negedge core_clk);
        s = 1'h1;
        @(negedge core_clk);
        s = 1'h0;
    endtask : strobe
    task automatic setLen(input logic [SEL_W-1:0] idx, input logic [LEN_CODE_W-1:0] code);
        @(negedge core_clk);
        cfgIn = '{1'h1, idx, code};
        @(negedge core_clk);
        cfgIn.cfgWrite = 1'h0;
    endtask : setLen
    task automatic send(input logic [WORD_W-1:0] w, input logic dma);
        @(negedge core_clk);
        txIn = '{dma, w};
        txValid = 1'h1;
        while (txReady !== 1'h1) @(negedge core_clk);
        @(negedge core_clk);
        txValid = 1'h0;
    endtask : send
    task automatic waitIdle;
        repeat (2) @(negedge core_clk);
        repeat (2000) begin
            if (transmitDrained === 1'h1) break;
            @(negedge core_clk);
        end
        repeat (4) @(negedge core_clk);
    endtask : waitIdle
    // An external master clocks one byte in; the clock stands still outside the frame.
    task automatic slaveFrame(input logic [7:0] v);
        selIn_n = 1'h0;
        slvData = v[7];
        #80 slvRun = 1'h1;
        for (int i = 6; i >= -1; i--) begin
            @(negedge slaveClk);
            slvData = (i >= 0) ? v[i] : !slvData;
        end
        slvRun = 1'h0;
        #80 selIn_n = 1'h1;
    endtask : slaveFrame
    function automatic logic [DATA_W-1:0] lowBits(input logic [DATA_W-1:0] v, input int n);
        return v & DATA_W'((32'h1 << n) - 1);
    endfunction : lowBits
    function automatic int expPulses(input int n, input logic [DIV_W-1:0] div);
        return n + int'(div == DIV_ONE && n % 2 == 1);
    endfunction : expPulses
////////////////////////////////////////////////////////////
    initial begin
        #2ms failCount++;
        endSim();
    end
    initial begin
        logic [WORD_W-1:0] w;
        logic [DIV_W-1:0]  div;
        void'($urandom(56941));
        repeat (3) @(negedge core_clk);
        rst_n = 1'h1;
        `CHK(selOut_n, SEL_IDLE)
        `CHK(transmitDrained, 1'h1)
        strobe(softResetCmd);
        strobe(softResetCmd);
        masterSel = 1'h1;
        strobe(enableCmd);
        for (int code = 0; code <= 8; code++) begin
            for (int k = 0; k < 2; k++) begin
                div = k ? DIV_W'(2 + $urandom_range(3)) : DIV_ONE;
                setLen('0, LEN_CODE_W'(code));
                clockDivider = div;
                curLen = LEN_W'(8 + code);
                reply = DATA_W'($urandom);
                w = $urandom & 32'hFEFC_FFFF;
                send(w, 1'h0);
                waitIdle();
                `CHK(pulses, expPulses(8 + code, div))
                `CHK(captured, lowBits(w[15:0], 8 + code))
                if (div >= 8'h04) `CHK(rxData, lowBits(reply, 8 + code))
                strobe(rxTake);
            end
        end
        `CHK(strayCount, 0)
        fixedMode = 1'h1;
        selIndex = 2'h1;
        for (int k = 0; k < 2; k++) begin
            setLen('0, k ? 4'h0 : 4'h2);
            setLen(2'h1, 4'h0);
            send(32'h0000_00A5, 1'h1);
            repeat (200) if (selOut_n[1] !== 1'h0) @(negedge core_clk);
            `CHK(dmaHalfword, k ? 1'h0 : 1'h1)
            waitIdle();
            strobe(rxTake);
        end
        // Hold with divider one is forbidden to software; set here to expose the resend.
        fixedMode = 1'h0;
        holdSelect = 1'h1;
        clockDivider = DIV_ONE;
        curLen = LEN_BASE;
        send(32'h0000_003C, 1'h0);
        waitIdle();
        send(32'h0000_00C3, 1'h0);
        waitIdle();
        `CHK(pulses, 24)
        `CHK(captured, 16'h003C)
        strobe(softResetCmd);
        strobe(softResetCmd);
        fixedMode = 1'h1;
        selIndex = 2'h0;
        clockDivider = 8'h02;
        strobe(enableCmd);
        send(32'h0000_0011, 1'h1);
        waitIdle();
        `CHK(selOut_n[0], 1'h0)
        send(32'h0100_0022, 1'h1);
        waitIdle();
        `CHK(selOut_n, SEL_IDLE)
        holdSelect = 1'h0;
        fixedMode = 1'h0;
        strayCount = 0;
        strobe(softResetCmd);
        strobe(enableCmd);
        send(32'h0000_0055, 1'h0);
        waitIdle();
        `CHK(strayCount > 0, 1'h1)
        strobe(softResetCmd);
        strayCount = 0;
        masterSel = 1'h0;
        setLen(2'h1, 4'h0);
        masterSel = 1'h1;
        strobe(enableCmd);
        repeat (40) @(negedge core_clk);
        `CHK(strayCount > 0, 1'h1)
        strobe(softResetCmd);
        strobe(softResetCmd);
        masterSel = 1'h0;
        strobe(enableCmd);
        strobe(disableCmd);
        `CHK(enabled, 1'h1)
        w = $urandom;
        slaveFrame(w[7:0]);
        repeat (40) if (rxValid !== 1'h1) @(negedge core_clk);
        `CHK(rxData, {8'h00, w[7:0]})
        strobe(rxTake);
        strobe(softResetCmd);
        strobe(softResetCmd);
        `CHK(enabled, 1'h0)
        endSim();
    end
endmodule : test_scq_controller
